// ==== test/csp_far.sv ====
module csp_far (
  input  wire logic       mclk,    // System clock
  input  wire logic       ext,     // Far end makes the clock
  input  wire logic       dev_clk, // Device clock output
  input  wire logic       sout,    // Device serial out
  input  wire logic [7:0] tx,      // Byte to send
  input  wire logic       go,      // Start a frame
  output logic            pin,     // Clock pin level
  output logic            sin,     // Serial in level
  output logic [7:0]      rx       // Byte captured
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       own   = 1'b1;
  logic       pin_q = 1'b1;
  logic       sin_r = 1'b0;
  logic [7:0] rx_r  = 8'h00;
  int         h     = 0;
  int         t     = 0;
  int         k     = 8;
  // Own clock stands high outside frames
  assign pin = ext ? own : dev_clk;
  assign sin = sin_r;
  assign rx  = rx_r;
  // Half period of 12 stays slower than the fastest rate
  always @(posedge mclk) begin
    pin_q <= pin;
    if (go) begin
      {k, h, t} <= {32'd0, 32'd0, ext ? 32'd16 : 32'd0};
    end else if (t > 0 && h == 11) begin
      {own, t, h} <= {~own, t - 1, 32'd0};
    end else if (t > 0) begin
      h <= h + 1;
    end
    if (pin && !pin_q && k < 8) begin
      rx_r <= {sout, rx_r[7:1]};
      k  <= k + 1;
    end
    // Line churns between frames so stale bits never match
    if (go) begin
      sin_r <= tx[0];
    end else if (k >= 8) begin
      sin_r <= ~sin_r;
    end else if (!pin && pin_q) begin
      sin_r <= tx[k];
    end
  end
endmodule

// ==== test/csp_top_asserts.sv ====
module csp_top_asserts (
  input wire logic               mclk,              // Clock
  input wire logic               rst,               // Reset
  input wire logic [7:0]         cpu_addr,          // Address
  input wire logic               cpu_wr,            // Write
  input wire logic               cpu_rd,            // Read
  input wire csp_pkg::csp_byte_t cpu_rdata,         // Read data
  input wire logic               irq_req,           // Irq
  input wire logic               io_halt_mode,      // Halt
  input wire logic               serial_clock_out,  // Clock out
  input wire logic               serial_clock_oe_n, // Clock oe
  input wire logic               rx_valid           // Fifo
);
  timeunit 1ns;
  timeprecision 1ns;
  import csp_pkg::*;
  // One domain, so one clock and one disable
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Idle outputs once reset lets go
  property p_rst; $fell(rst) |-> serial_clock_oe_n && !irq_req && !rx_valid; endproperty
  a_rst: assert property (p_rst) else $error("idle state wrong after reset");
  property p_halt; io_halt_mode [*3] |-> !irq_req; endproperty
  a_halt: assert property (p_halt) else $error("irq held in halt");
  property p_ext; serial_clock_oe_n |-> serial_clock_out; endproperty
  a_ext: assert property (p_ext) else $error("clock driven in external mode");
  // Fastest code gives ten cycles per half period
  property p_half; $fell(serial_clock_out) && !serial_clock_oe_n |=> $stable(serial_clock_out) [*8]; endproperty
  a_half: assert property (p_half) else $error("clock half period short");
  property p_irq; irq_req |-> serial_clock_out; endproperty
  a_irq: assert property (p_irq) else $error("irq while clock low");
  property p_rxv; $rose(rx_valid) |-> serial_clock_out; endproperty
  a_rxv: assert property (p_rxv) else $error("push before frame end");
  // Pin direction moves only with a control write
  property p_oe; $changed(serial_clock_oe_n) |-> $past(cpu_wr) && $past(cpu_addr) == 8'h0a; endproperty
  a_oe: assert property (p_oe) else $error("pin direction moved alone");
  property p_bit3; cpu_rd && cpu_addr == 8'h0a |=> !cpu_rdata[3]; endproperty
  a_bit3: assert property (p_bit3) else $error("control bit 3 set");
  c_tx: cover property ($rose(irq_req));
  c_rx: cover property ($rose(rx_valid));
  c_halt: cover property (io_halt_mode && $fell(irq_req));
endmodule

bind csp_top csp_top_asserts chk_u (
  .mclk              (mclk),
  .rst               (rst),
  .cpu_addr          (cpu_addr),
  .cpu_wr            (cpu_wr),
  .cpu_rd            (cpu_rd),
  .cpu_rdata         (cpu_rdata),
  .irq_req           (irq_req),
  .io_halt_mode      (io_halt_mode),
  .serial_clock_out  (serial_clock_out),
  .serial_clock_oe_n (serial_clock_oe_n),
  .rx_valid          (rx_valid)
);

// ==== test/testbench.sv ====
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, cpu_wr = 0, cpu_rd = 0, io_halt_mode = 0, cts_ch1_enable = 0;
  logic rx_ready = 0, ext = 0, go = 0, irq_req, rx_valid, serial_in_pin, serial_out_pin;
  logic serial_clock_in, serial_clock_out, serial_clock_oe_n;
  logic [7:0] cpu_addr = 0, cpu_wdata = 0, cpu_rdata, rx_byte, tx_b = 0, far_rx, d;
  int n_mismatch = 0, checks_done = 0, n;
  csp_top #(.FIFO_DEPTH(32)) dut_u (
    .mclk              (mclk),
    .rst               (rst),
    .cpu_addr          (cpu_addr),
    .cpu_wr            (cpu_wr),
    .cpu_rd            (cpu_rd),
    .cpu_wdata         (cpu_wdata),
    .cpu_rdata         (cpu_rdata),
    .irq_req           (irq_req),
    .io_halt_mode      (io_halt_mode),
    .cts_ch1_enable    (cts_ch1_enable),
    .serial_in_pin     (serial_in_pin),
    .serial_out_pin    (serial_out_pin),
    .serial_clock_in   (serial_clock_in),
    .serial_clock_out  (serial_clock_out),
    .serial_clock_oe_n (serial_clock_oe_n),
    .rx_byte           (rx_byte),
    .rx_valid          (rx_valid),
    .rx_ready          (rx_ready)
  );
  csp_far far_u (.mclk(mclk), .ext(ext), .dev_clk(serial_clock_out), .sout(serial_out_pin),
    .tx(tx_b), .go(go), .pin(serial_clock_in), .sin(serial_in_pin), .rx(far_rx));
  // 100 ns period
  initial forever #50 mclk = ~mclk;
  // Inputs move 1 ns after the edge
  task automatic step(int k = 1); repeat (k) @(posedge mclk); #1; endtask
  task automatic wr(logic [7:0] a, v);
    {cpu_addr, cpu_wdata, cpu_wr} = {a, v, 1'b1};
    step();
    cpu_wr = 0;
    step();
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] v);
    {cpu_addr, cpu_rd} = {a, 1'b1};
    step();
    cpu_rd = 0;
    v = cpu_rdata;
    step();
  endtask
  task automatic sclk_to(logic v); for (n = 0; n < 1300 && serial_clock_out !== v; n++) step(); endtask
  task automatic poll; int k = 0; do begin rd(8'h0a, d); k++; end while (d[7] !== 1'b1 && k < 300); endtask
  task automatic frame(logic [7:0] v, c);
    wr(8'h0a, c);
    {tx_b, go} = {v, 1'b1};
    step();
    go = 0;
  endtask
  task automatic halt; io_halt_mode = 1; step(3); io_halt_mode = 0; endtask
  task automatic t_ctrl;
    rd(8'h0a, d); `CHK(d, 8'h07)
    wr(8'h0a, 8'h08);
    rd(8'h0a, d); `CHK(d, 8'h00)
    `CHK({serial_clock_oe_n, serial_clock_out}, 2'b01)
    wr(8'h0a, 8'h37);
    rd(8'h0a, d); `CHK(d, 8'h07)
  endtask
  task automatic t_tx;
    wr(8'h0b, 8'ha5);
    frame(8'h00, 8'h50);
    for (n = 0; n < 400 && irq_req !== 1'b1; n++) step();
    // Far end sees the last rise one clock after the device does
    step();
    `CHK(far_rx, 8'ha5)
    `CHK(irq_req, 1'b1)
    rd(8'h0a, d); `CHK(d, 8'hc0)
    halt();
    rd(8'h0a, d); `CHK(d, 8'h40)
    `CHK(irq_req, 1'b0)
    // Halt while the clock is high, mid frame
    frame(8'h00, 8'h50);
    sclk_to(0);
    sclk_to(1);
    halt();
    rd(8'h0a, d); `CHK(d, 8'h40)
  endtask
  task automatic t_rates;
    for (int s = 0; s < 7; s++) begin
      wr(8'h0a, {5'h02, 3'(s)});
      sclk_to(0);
      sclk_to(1);
      `CHK(n, 10 << s)
      wr(8'h0a, 8'(s));
      rd(8'h0a, d); `CHK(d, 8'(s))
    end
  endtask
  // Consumer stalls until the FIFO refuses a frame
  task automatic t_rx_fifo;
    ext = 1;
    for (int i = 0; i < 32; i++) begin
      frame(8'(i * 7), 8'h27);
      poll(); `CHK(d, 8'h87)
      rd(8'h0b, d); `CHK(d, 8'(i * 7))
      rd(8'h0a, d); `CHK(d, 8'h07)
    end
    frame(8'h5a, 8'h27);
    step(400);
    rd(8'h0a, d); `CHK(d, 8'h27)
    wr(8'h0a, 8'h07);
    rx_ready = 1;
    for (int i = 0; i < 32; i++) begin `CHK(rx_byte, 8'(i * 7)) step(); end
    `CHK(rx_valid, 1'b0)
    {rx_ready, ext} = 2'b00;
  endtask
  task automatic t_cts;
    cts_ch1_enable = 1;
    frame(8'h00, 8'h20);
    poll(); `CHK(d, 8'h80)
    rd(8'h0b, d); `CHK(d, 8'hff)
    cts_ch1_enable = 0;
  endtask
  // Internal receive of live data, then echo it on the far end's clock
  task automatic t_modes;
    frame(8'h3c, 8'h20);
    poll(); `CHK(d, 8'h80)
    rd(8'h0b, d); `CHK(d, 8'h3c)
    ext = 1;
    frame(8'h00, 8'h17);
    `CHK(serial_clock_oe_n, 1'b1)
    poll(); `CHK(d, 8'h87)
    `CHK(far_rx, 8'h3c)
    wr(8'h0b, 8'h00);
    rd(8'h0a, d); `CHK(d, 8'h07)
    ext = 0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    step(10);
    rst = 0;
    t_ctrl();
    t_tx();
    t_rates();
    t_rx_fifo();
    t_cts();
    t_modes();
    conclude();
  end
  // About five times the expected run
  initial begin
    #5000000;
    n_mismatch++;
    conclude();
  end
endmodule

// ==== verilog/csp_cfg.svh ====
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH
// Register addresses on the processor I/O port
`define CSP_ADDR_CTRL 8'h0a
`define CSP_ADDR_DATA 8'h0b
// Control register field positions
`define CSP_BIT_DONE 7
`define CSP_BIT_IRQEN 6
`define CSP_BIT_RXEN 5
`define CSP_BIT_TXEN 4
`define CSP_SS_MSB 2
// Reset values
`define CSP_SS_RESET 3'h7
`define CSP_DATA_RESET 8'h00
// Speed code that hands the clock to the pin
`define CSP_SS_EXTERNAL 3'h7
// Smallest divide ratio of the system clock
`define CSP_DIV_BASE 20
// Clock period in ns (10 MHz)
`define CSP_MCLK_NS 100
`endif

// ==== verilog/csp_pkg.sv ====
package csp_pkg;
  // Engine state, one-hot
  typedef enum logic [2:0] {
    CSP_IDLE = 3'b001,
    CSP_TX   = 3'b010,
    CSP_RX   = 3'b100
  } csp_state_e;
  typedef logic [7:0] csp_byte_t;
  typedef logic [2:0] csp_speed_t;
endpackage

// ==== verilog/csp_top.sv ====
`include "csp_cfg.svh"

// Receive FIFO; DEPTH must be a power of two
module csp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             mclk,      // System clock
  input  wire logic             rst,       // Sync reset
  input  wire logic [WIDTH-1:0] in_data,   // Write data
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Space left
  output logic [WIDTH-1:0]      out_data,  // Head word
  output logic                  out_valid, // Not empty
  input  wire logic             out_ready  // Consumer takes head
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    wp_nxt;
  logic [AW-1:0]    rp_r;
  logic [AW-1:0]    rp_nxt;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             push;
  logic             pop;
  logic             valid_r;
  logic             valid_nxt;
  logic [WIDTH-1:0] head_r;
  logic [WIDTH-1:0] head_nxt;

  // Both stream outputs come straight from flops
  assign in_ready  = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = valid_r;
  assign out_data  = head_r;

  // Pointer and level update; pointers wrap by width
  always_comb begin
    push    = in_valid & in_ready;
    pop     = out_valid & out_ready;
    wp_nxt  = wp_r + AW'(push);
    rp_nxt  = rp_r + AW'(pop);
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    valid_nxt = cnt_nxt != '0;
    // Registered head; a push into a draining FIFO bypasses storage
    head_nxt  = (push && wp_r == rp_nxt) ? in_data : mem_r[rp_nxt];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      valid_r <= 1'b0;
      head_r  <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      valid_r <= valid_nxt;
      head_r  <= head_nxt;
    end
  end

  // Storage needs no reset; empty flag guards it
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule

// Notes on behaviour
// - Frames are 8 bits; only one of transmit or receive runs at once.
// - Done flag, control bit 7, sets when a byte finishes shifting.
// - A read or write of the data register clears the done flag, unless a byte completes in the same cycle.
// - Reset and halt mode clear the done flag.
// - Interrupt request is done flag AND interrupt enable bit 6.
// - Writing 1 to bit 5 starts a receive and runs the data clock.
// - Internal mode drives the clock pin; external mode takes it in.
// - Receive shifts the serial input on each active clock edge.
// - After 8 received bits, receive enable clears and done flag sets.
// - Writing 1 to bit 4 starts a transmit shifting out serial data.
// - After 8 sent bits, transmit enable clears and done flag sets.
// - Receive and transmit enables are never both set.
// - Reset clears both enables; halt mode clears them too.
// - Serial input works only when channel 1 clear-to-send is disabled.
// - Bits 2-0 pick clock source and rate; reset sets them to 111.
// - Codes 0-6 divide by 20 up to 1280; 111 is external.
// - Non-external code makes the pin an output, toggling only when enabled.
// - Data register is unbuffered; writes hit the shifting byte at once.
// - Clearing an enable aborts its transfer at once.
module csp_top
  import csp_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic              mclk,              // System clock
  input  wire logic              rst,               // Sync reset, high
  input  wire logic [7:0]        cpu_addr,          // I/O address
  input  wire logic              cpu_wr,            // Write strobe
  input  wire logic              cpu_rd,            // Read strobe
  input  wire csp_pkg::csp_byte_t cpu_wdata,        // Write data
  output csp_pkg::csp_byte_t     cpu_rdata,         // Read data, next cycle
  output logic                   irq_req,           // Interrupt request
  input  wire logic              io_halt_mode,      // I/O stop mode
  input  wire logic              cts_ch1_enable,    // Shared pad owner
  input  wire logic              serial_in_pin,     // Serial data in
  output logic                   serial_out_pin,    // Serial data out
  input  wire logic              serial_clock_in,   // Clock pin input
  output logic                   serial_clock_out,  // Clock pin output
  output logic                   serial_clock_oe_n, // Low while driving
  output csp_pkg::csp_byte_t     rx_byte,           // Received byte stream
  output logic                   rx_valid,          // Stream word valid
  input  wire logic              rx_ready           // Stream consumer ready
);
  import csp_pkg::*;

  localparam int DIV_W = 11;

  csp_state_e state_r;
  csp_state_e state_nxt;
  csp_byte_t  data_r;
  csp_byte_t  data_nxt;
  csp_speed_t ss_r;
  csp_speed_t ss_nxt;
  logic       ef_r;
  logic       ef_nxt;
  logic       eie_r;
  logic       eie_nxt;
  logic [2:0] bit_r;
  logic [2:0] bit_nxt;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic       sclk_r;
  logic       sclk_nxt;
  logic       sclk_in_d_r;
  logic       sout_r;
  logic       sout_nxt;
  logic       irq_r;
  logic       irq_nxt;
  csp_byte_t  rdata_r;
  csp_byte_t  rdata_nxt;
  logic       ck_oe_n_r;
  logic       ck_oe_n_nxt;
  logic       push;
  logic       fifo_ready;
  logic       wr_ctrl;
  logic       wr_data;
  logic       rd_ctrl;
  logic       rd_data;
  logic       ext;
  logic       stall;
  logic       tick;
  logic       rise;
  logic       fall;
  logic       done;
  logic       rx_bit;
  logic       new_tx;
  logic       new_rx;

  // Half period of the internal clock in system clocks
  function automatic logic [DIV_W-1:0] half_period(input csp_speed_t ss);
    half_period = DIV_W'(`CSP_DIV_BASE / 2) << ss;
  endfunction

  // Control register image; bit 3 always zero
  function automatic csp_byte_t ctrl_image(input logic ef, input logic done_irq_enable,
                                           input csp_state_e st, input csp_speed_t ss);
    ctrl_image = {ef, done_irq_enable, st == CSP_RX, st == CSP_TX, 1'b0, ss};
  endfunction

  // Address decode of the processor port
  always_comb begin
    wr_ctrl = cpu_wr && cpu_addr == `CSP_ADDR_CTRL;
    wr_data = cpu_wr && cpu_addr == `CSP_ADDR_DATA;
    rd_ctrl = cpu_rd && cpu_addr == `CSP_ADDR_CTRL;
    rd_data = cpu_rd && cpu_addr == `CSP_ADDR_DATA;
    new_tx  = cpu_wdata[`CSP_BIT_TXEN];
    new_rx  = cpu_wdata[`CSP_BIT_RXEN];
  end

  // Clock edges; a full FIFO freezes receive: the internal clock holds, external edges are dropped
  always_comb begin
    ext    = ss_r == `CSP_SS_EXTERNAL;
    stall  = state_r == CSP_RX && !fifo_ready;
    rx_bit = cts_ch1_enable ? 1'b1 : serial_in_pin;
    tick   = 1'b0;
    div_nxt  = '0;
    sclk_nxt = 1'b1;
    if (state_r != CSP_IDLE && !ext && !stall) begin
      tick     = div_r == half_period(ss_r) - DIV_W'(1);
      div_nxt  = tick ? '0 : div_r + DIV_W'(1);
      sclk_nxt = tick ? !sclk_r : sclk_r;
    end else if (state_r != CSP_IDLE && !ext) begin
      div_nxt  = div_r;
      sclk_nxt = sclk_r;
    end
    // External edges compare the pin with its copy from one clock earlier in the delay stage
    if (ext) begin
      rise = state_r != CSP_IDLE && !stall && serial_clock_in && !sclk_in_d_r;
      fall = state_r != CSP_IDLE && !stall && !serial_clock_in && sclk_in_d_r;
    end else begin
      rise = tick && !sclk_r;
      fall = tick && sclk_r;
    end
  end

  // Shift engine, control register and data register
  always_comb begin
    state_nxt = state_r;
    data_nxt  = data_r;
    bit_nxt   = bit_r;
    sout_nxt  = sout_r;
    ss_nxt    = ss_r;
    eie_nxt   = eie_r;
    done      = 1'b0;
    push      = 1'b0;
    if (rise) begin
      bit_nxt = bit_r + 3'h1;
      if (state_r == CSP_RX) begin
        data_nxt = {rx_bit, data_r[7:1]};
      end
      if (bit_r == 3'h7) begin
        done      = 1'b1;
        push      = state_r == CSP_RX;
        state_nxt = CSP_IDLE;
      end
    end
    // First fall precedes any rise and keeps bit 0 on the pin
    if (fall && state_r == CSP_TX && bit_r != 3'h0) begin
      data_nxt = {1'b0, data_r[7:1]};
      sout_nxt = data_r[1];
    end
    // Unbuffered: a write lands in the shifter immediately
    if (wr_data) begin
      data_nxt = cpu_wdata;
    end
    if (wr_ctrl) begin
      eie_nxt = cpu_wdata[`CSP_BIT_IRQEN];
      ss_nxt  = cpu_wdata[`CSP_SS_MSB:0];
      unique case (state_nxt)
        CSP_TX: begin
          if (!new_tx) begin
            state_nxt = CSP_IDLE;
          end
        end
        CSP_RX: begin
          if (!new_rx) begin
            state_nxt = CSP_IDLE;
          end
        end
        CSP_IDLE: begin
          // A write asking for both directions starts neither
          if (new_tx && !new_rx) begin
            state_nxt = CSP_TX;
            bit_nxt   = 3'h0;
            sout_nxt  = wr_data ? cpu_wdata[0] : data_r[0];
          end else if (new_rx && !new_tx) begin
            state_nxt = CSP_RX;
            bit_nxt   = 3'h0;
          end
        end
      endcase
    end
    if (io_halt_mode) begin
      state_nxt = CSP_IDLE;
    end
  end

  // Done flag: completion beats a same-cycle clear; halt beats both
  always_comb begin
    ef_nxt = ef_r;
    if (wr_data || rd_data) begin
      ef_nxt = 1'b0;
    end
    if (done) begin
      ef_nxt = 1'b1;
    end
    if (io_halt_mode) begin
      ef_nxt = 1'b0;
    end
    irq_nxt     = ef_nxt && eie_nxt;
    ck_oe_n_nxt = ss_nxt == `CSP_SS_EXTERNAL;
    rdata_nxt   = 8'h00;
    if (rd_ctrl) begin
      rdata_nxt = ctrl_image(ef_r, eie_r, state_r, ss_r);
    end else if (rd_data) begin
      rdata_nxt = data_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r     <= CSP_IDLE;
      data_r      <= `CSP_DATA_RESET;
      ss_r        <= `CSP_SS_RESET;
      ef_r        <= 1'b0;
      eie_r       <= 1'b0;
      bit_r       <= 3'h0;
      div_r       <= '0;
      sclk_r      <= 1'b1;
      sclk_in_d_r <= 1'b1;
      sout_r      <= 1'b1;
      irq_r       <= 1'b0;
      rdata_r     <= 8'h00;
      ck_oe_n_r   <= 1'b1;
    end else begin
      state_r     <= state_nxt;
      data_r      <= data_nxt;
      ss_r        <= ss_nxt;
      ef_r        <= ef_nxt;
      eie_r       <= eie_nxt;
      bit_r       <= bit_nxt;
      div_r       <= div_nxt;
      sclk_r      <= sclk_nxt;
      sclk_in_d_r <= serial_clock_in;
      sout_r      <= sout_nxt;
      irq_r       <= irq_nxt;
      rdata_r     <= rdata_nxt;
      ck_oe_n_r   <= ck_oe_n_nxt;
    end
  end

  // Received bytes also leave as a stream
  csp_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_data   (data_nxt),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .out_data  (rx_byte),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  assign cpu_rdata         = rdata_r;
  assign irq_req           = irq_r;
  assign serial_out_pin    = sout_r;
  assign serial_clock_out  = sclk_r;
  assign serial_clock_oe_n = ck_oe_n_r;
endmodule
